// ==== src/dcbr_defines.vh ====
// constants for the dual core boot and reset sequencer
`ifndef DCBR_DEFINES_VH
`define DCBR_DEFINES_VH
// primary boot strap codes
`define DCBR_MODE_PARALLEL 4'h0
`define DCBR_MODE_RAM 4'h1
`define DCBR_MODE_SERIAL_SLV 4'h2
`define DCBR_MODE_CAN 4'h3
`define DCBR_MODE_ETH 4'h4
`define DCBR_MODE_FLASH 4'h7
`define DCBR_MODE_SSI_MST 4'h9
`define DCBR_MODE_I2C_MST 4'hA
`define DCBR_MODE_FLASH_ALT 4'hF
// primary boot source encoding
`define DCBR_SRC_FLASH 3'h0
`define DCBR_SRC_RAM 3'h1
`define DCBR_SRC_PARALLEL 3'h2
`define DCBR_SRC_SERIAL_SLV 3'h3
`define DCBR_SRC_CAN 3'h4
`define DCBR_SRC_ETH 3'h5
`define DCBR_SRC_SSI_MST 3'h6
`define DCBR_SRC_I2C_MST 3'h7
// secondary boot command values
`define DCBR_CMD_RAM 32'h00000001
`define DCBR_CMD_FLASH 32'h00000002
`define DCBR_CMD_ASYNC 32'h00000003
`define DCBR_CMD_SPI 32'h00000004
`define DCBR_CMD_I2C 32'h00000005
`define DCBR_CMD_PARALLEL 32'h00000006
// secondary entry encoding
`define DCBR_SEC_NONE 3'h0
`define DCBR_SEC_RAM 3'h1
`define DCBR_SEC_FLASH 3'h2
`define DCBR_SEC_ASYNC 3'h3
`define DCBR_SEC_SPI 3'h4
`define DCBR_SEC_I2C 3'h5
`define DCBR_SEC_PARALLEL 3'h6
`define DCBR_SEC_HOUSEKEEP 3'h7
// timing: power-on hold time in ns, cycles at 25 ns period rounded up
`define DCBR_POR_HOLD_NS 1000
`define DCBR_CLK_PERIOD_NS 25
`define DCBR_POR_HOLD_CYC ((`DCBR_POR_HOLD_NS + `DCBR_CLK_PERIOD_NS - 1) / `DCBR_CLK_PERIOD_NS)
`endif

// ==== src/dcbr_sequencer.v ====
// boot and reset sequencer for a dual-processor device
//
// Summary of operation
// [R1] Straps 7 or 15 boot primary flash; invalid flash faults and restarts sequence.
// [R2] Straps 0001b boot primary RAM holding preloaded code.
// [R3] Straps 0000b load image over parallel pins, then jump.
// [R4] Straps 0010b load over UART, sync serial or I2C as slaves.
// [R5] Straps 0100b load image over Ethernet.
// [R6] Straps 1001b sync serial master, 1010b I2C master load.
// [R7] Once image resides in flash or RAM, hand control to application.
// [R8] Secondary idles after init until wake interrupt one arrives.
// [R9] Command 1 jumps secondary to RAM, 2 to flash.
// [R10] Commands 3 to 6 load secondary from async, SPI, I2C, parallel.
// [R11] After boot, secondary keeps accepting housekeeping commands.
// [R12] Power-on reset drives both reset pins low, regulators notwithstanding.
// [R13] External parties may hold reset pins low to stretch reset.
// [R14] Power-on reset resets both subsystems, tristates all general pins.
// [R15] Core, watchdog and NMI resets combined, ANDed with POR onto reset pin.
// [R16] Secondary and analog stay in reset until release bits written 1.
// [R17] Pull-ups disabled after reset; board supplies strap pull-ups.
// [R18] Straps 0011b load image over CAN.
// [R19] Unsupported strap codes default to primary flash boot.
// [R20] Straps sampled once per sequence, held until application runs.
`timescale 1ns/100ps
`include "dcbr_defines.vh"
module dcbr_sequencer #(
  parameter POR_CYCLES = `DCBR_POR_HOLD_CYC
) (
  // clock and power-on reset
  input wire clk_in,
  input wire sys_rst_in,
  // strap pins, asynchronous
  input wire [3:0] strap_pins_in,
  // reset requests from core logic, asynchronous
  input wire core_irq_reset_in,
  input wire watchdog0_reset_in,
  input wire watchdog1_reset_in,
  input wire nmi_watchdog_reset_in,
  // open-drain reset pins, sensed level
  input wire digital_reset_pin_in,
  input wire analog_reset_pin_in,
  // primary boot progress from loaders
  input wire image_loaded_in,
  input wire flash_valid_in,
  // release bits written by primary processor
  input wire secondary_core_reset_release_in,
  input wire analog_interface_reset_release_in,
  // interprocessor channel from primary application
  input wire primary_to_secondary_wake_irq_in,
  input wire [31:0] secondary_boot_command_value_in,
  input wire command_strobe_in,
  // reset pin drivers, oe high pulls pin low
  output reg digital_reset_pin_out,
  output reg digital_reset_pin_oe_out,
  output reg analog_reset_pin_out,
  output reg analog_reset_pin_oe_out,
  // general pin control
  output reg gpio_tristate_out,
  output reg gpio_pullup_en_out,
  // subsystem reset outputs, active low
  output reg primary_reset_n_out,
  output reg secondary_reset_n_out,
  output reg analog_reset_n_out,
  // primary boot status
  output reg [3:0] boot_mode_out,
  output reg [2:0] boot_source_out,
  output reg loader_active_out,
  output reg app_running_out,
  output reg boot_fault_out,
  // secondary boot status
  output reg secondary_idle_out,
  output reg [2:0] secondary_entry_out,
  output reg secondary_app_out
);
  localparam ST_POR = 3'h0;
  localparam ST_SAMPLE = 3'h1;
  localparam ST_LOAD = 3'h2;
  localparam ST_CHECK = 3'h3;
  localparam ST_RUN = 3'h4;
  localparam ST_FAULT = 3'h5;
  localparam CNT_W = 16;
  // load value cut to the counter width on purpose
  localparam [CNT_W-1:0] POR_LOAD = POR_CYCLES[CNT_W-1:0];

  wire [9:0] sync_bits;
  wire [3:0] strap_sync;
  wire reset_req;
  wire pin_low;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] por_cnt;
  reg [2:0] next_source;
  reg next_loader;
  reg [2:0] next_entry;

  // every pin input passes two flops before use, sensed reset pins included
  dcbr_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({strap_pins_in, digital_reset_pin_in, analog_reset_pin_in,
               core_irq_reset_in, watchdog0_reset_in,
               watchdog1_reset_in, nmi_watchdog_reset_in}),
    .rst_val_in(10'h000),
    .sync_out(sync_bits)
  );
  assign strap_sync = sync_bits[9:6];
  // [R15] merge reset sources
  assign reset_req = |sync_bits[3:0];
  // [R13] pin sensed low from outside stretches reset for both subsystems
  // synchronised pins reset low, so reset reads as stretched until they settle
  assign pin_low = ~sync_bits[5] | ~sync_bits[4];

  // [R19] decode strap code; unsupported codes fall back to flash
  always @* begin
    next_source = `DCBR_SRC_FLASH;
    next_loader = 1'b0;
    case (strap_sync)
      // [R3] parallel pin loader
      `DCBR_MODE_PARALLEL: begin
        next_source = `DCBR_SRC_PARALLEL;
        next_loader = 1'b1;
      end
      // [R2] preloaded RAM
      `DCBR_MODE_RAM: next_source = `DCBR_SRC_RAM;
      // [R4] serial ports as slaves
      `DCBR_MODE_SERIAL_SLV: begin
        next_source = `DCBR_SRC_SERIAL_SLV;
        next_loader = 1'b1;
      end
      // [R18] CAN loader
      `DCBR_MODE_CAN: begin
        next_source = `DCBR_SRC_CAN;
        next_loader = 1'b1;
      end
      // [R5] Ethernet loader
      `DCBR_MODE_ETH: begin
        next_source = `DCBR_SRC_ETH;
        next_loader = 1'b1;
      end
      // [R6] serial masters
      `DCBR_MODE_SSI_MST: begin
        next_source = `DCBR_SRC_SSI_MST;
        next_loader = 1'b1;
      end
      `DCBR_MODE_I2C_MST: begin
        next_source = `DCBR_SRC_I2C_MST;
        next_loader = 1'b1;
      end
      // [R1] modes 7 and 15 go to flash
      `DCBR_MODE_FLASH: next_source = `DCBR_SRC_FLASH;
      `DCBR_MODE_FLASH_ALT: next_source = `DCBR_SRC_FLASH;
      default: next_source = `DCBR_SRC_FLASH;
    endcase
  end

  // primary boot sequence
  always @* begin
    next_state = state;
    case (state)
      ST_POR: begin
        if (por_cnt == {CNT_W{1'b0}} && !pin_low) begin
          next_state = ST_SAMPLE;
        end
      end
      // loader flag was registered together with the strap sample
      ST_SAMPLE: next_state = loader_active_out ? ST_LOAD : ST_CHECK;
      ST_LOAD: begin
        if (image_loaded_in) begin
          next_state = ST_RUN;
        end
      end
      ST_CHECK: begin
        // [R1] flash without valid code faults
        if (boot_source_out == `DCBR_SRC_FLASH && !flash_valid_in) begin
          next_state = ST_FAULT;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      // [R1] fault restarts the reset sequence
      ST_FAULT: next_state = ST_POR;
      default: next_state = ST_POR;
    endcase
    if (reset_req || pin_low) begin
      next_state = ST_POR;
    end
  end

  // state, counter and primary outputs
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_POR;
      por_cnt <= POR_LOAD;
      boot_mode_out <= 4'h0;
      boot_source_out <= `DCBR_SRC_FLASH;
      loader_active_out <= 1'b0;
      app_running_out <= 1'b0;
      boot_fault_out <= 1'b0;
      primary_reset_n_out <= 1'b0;
      gpio_tristate_out <= 1'b1;
      gpio_pullup_en_out <= 1'b0;
    end else begin
      state <= next_state;
      // reload only on entry, so a long hold just waits with the count at zero
      if (next_state == ST_POR && state != ST_POR) begin
        por_cnt <= POR_LOAD;
      end else if (por_cnt != {CNT_W{1'b0}}) begin
        por_cnt <= por_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // [R14] subsystems held and pins tristated during reset
      primary_reset_n_out <= (next_state != ST_POR);
      gpio_tristate_out <= (next_state == ST_POR);
      // [R17] pull-ups stay off after reset
      gpio_pullup_en_out <= 1'b0;
      // [R20] sample straps once per sequence, hold until run
      if (state == ST_POR && next_state == ST_SAMPLE) begin
        boot_mode_out <= strap_sync;
        boot_source_out <= next_source;
        loader_active_out <= next_loader;
      end
      // [R7] image resident, control passes to application
      // a load cut short by reset must not leave the loader flag set
      if (next_state == ST_RUN || next_state == ST_POR) begin
        loader_active_out <= 1'b0;
      end
      app_running_out <= (next_state == ST_RUN);
      boot_fault_out <= (next_state == ST_FAULT);
    end
  end

  // [R12] [R15] reset pins pulled low by power-on, digital pin also by merged requests
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      digital_reset_pin_out <= 1'b0;
      digital_reset_pin_oe_out <= 1'b1;
      analog_reset_pin_out <= 1'b0;
      analog_reset_pin_oe_out <= 1'b1;
    end else begin
      digital_reset_pin_out <= 1'b0;
      analog_reset_pin_out <= 1'b0;
      // analog pin follows the hold count only, which reloads on every return to reset; tied board pins carry requests across
      digital_reset_pin_oe_out <= (por_cnt != {CNT_W{1'b0}}) || reset_req;
      analog_reset_pin_oe_out <= (por_cnt != {CNT_W{1'b0}});
    end
  end

  // [R10] [R9] decode secondary boot command
  // unknown values decode to none and are refused while idle
  always @* begin
    case (secondary_boot_command_value_in)
      `DCBR_CMD_RAM: next_entry = `DCBR_SEC_RAM;
      `DCBR_CMD_FLASH: next_entry = `DCBR_SEC_FLASH;
      `DCBR_CMD_ASYNC: next_entry = `DCBR_SEC_ASYNC;
      `DCBR_CMD_SPI: next_entry = `DCBR_SEC_SPI;
      `DCBR_CMD_I2C: next_entry = `DCBR_SEC_I2C;
      `DCBR_CMD_PARALLEL: next_entry = `DCBR_SEC_PARALLEL;
      default: next_entry = `DCBR_SEC_NONE;
    endcase
  end

  // secondary release, idle wait and command handling
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      secondary_reset_n_out <= 1'b0;
      analog_reset_n_out <= 1'b0;
      secondary_idle_out <= 1'b0;
      secondary_entry_out <= `DCBR_SEC_NONE;
      secondary_app_out <= 1'b0;
    end else if (next_state == ST_POR) begin
      // secondary side follows every primary reset
      secondary_reset_n_out <= 1'b0;
      analog_reset_n_out <= 1'b0;
      secondary_idle_out <= 1'b0;
      secondary_entry_out <= `DCBR_SEC_NONE;
      secondary_app_out <= 1'b0;
    end else begin
      // [R16] release only on written 1; release is sticky until reset
      if (secondary_core_reset_release_in) begin
        secondary_reset_n_out <= 1'b1;
      end
      if (analog_interface_reset_release_in) begin
        analog_reset_n_out <= 1'b1;
      end
      // [R8] idle after init until wake interrupt one
      if (secondary_reset_n_out && !secondary_app_out && !secondary_idle_out
          && secondary_entry_out == `DCBR_SEC_NONE) begin
        secondary_idle_out <= 1'b1;
      end
      // a command needs wake, strobe and a known code in one cycle
      if (secondary_idle_out && primary_to_secondary_wake_irq_in && command_strobe_in
          && next_entry != `DCBR_SEC_NONE) begin
        secondary_idle_out <= 1'b0;
        secondary_entry_out <= next_entry;
        secondary_app_out <= 1'b1;
      end else if (secondary_app_out && command_strobe_in) begin
        // [R11] later commands are housekeeping requests
        secondary_entry_out <= `DCBR_SEC_HOUSEKEEP;
      end
    end
  end
endmodule

// ==== src/dcbr_sync.v ====
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module dcbr_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // data
  input wire [WIDTH-1:0] async_in,
  input wire [WIDTH-1:0] rst_val_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  genvar i;
  // one pair of flops per bit; first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate
  // rst_val_in is unused on purpose: reset takes constants only
  assign sync_out = stage2 | (rst_val_in & {WIDTH{1'b0}});
endmodule

// ==== verification/dcbr_board.sv ====
// board side model: tied open-drain reset pins with pull-ups and a supervisor
`timescale 1ns/100ps
module dcbr_board (
  // pin drivers from the device
  input wire logic dig_oe_in,
  input wire logic ana_oe_in,
  // supervisor stretching reset
  input wire logic hold_in,
  // resolved pin levels
  output wire logic dig_pin_out,
  output wire logic ana_pin_out
);
  // tied pins, either party drags both low
  // board pull-ups set the released level, not the device
  assign dig_pin_out = !(dig_oe_in || ana_oe_in || hold_in);
  assign ana_pin_out = dig_pin_out;
endmodule

// ==== verification/dcbr_checker.sv ====
// port checker for the boot and reset sequencer
`timescale 1ns/100ps
module dcbr_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // watched inputs
  input wire logic watchdog0_reset_in,
  input wire logic primary_to_secondary_wake_irq_in,
  // watched outputs
  input wire logic digital_reset_pin_oe_out,
  input wire logic analog_reset_pin_oe_out,
  input wire logic gpio_tristate_out,
  input wire logic gpio_pullup_en_out,
  input wire logic primary_reset_n_out,
  input wire logic secondary_reset_n_out,
  input wire logic [3:0] boot_mode_out,
  input wire logic [2:0] boot_source_out,
  input wire logic loader_active_out,
  input wire logic app_running_out,
  input wire logic boot_fault_out,
  input wire logic secondary_idle_out,
  input wire logic [2:0] secondary_entry_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // source per strap code; anything unlisted falls back to flash
  function automatic logic [2:0] src_of(input logic [3:0] m);
    case (m)
      4'h0: src_of = 3'h2;
      4'h1: src_of = 3'h1;
      4'h2: src_of = 3'h3;
      4'h3: src_of = 3'h4;
      4'h4: src_of = 3'h5;
      4'h9: src_of = 3'h6;
      4'hA: src_of = 3'h7;
      default: src_of = 3'h0;
    endcase
  endfunction
  a_por_pins_low: assert property ($fell(sys_rst_in) |->
    digital_reset_pin_oe_out && analog_reset_pin_oe_out)
    else $error("reset pins not held after power-on");
  a_por_gpio_hiz: assert property ($fell(sys_rst_in) |->
    gpio_tristate_out && !secondary_reset_n_out)
    else $error("pins not tristated in power-on reset");
  a_pullup_off: assert property (!gpio_pullup_en_out)
    else $error("pull-ups enabled");
  a_request_pin: assert property (watchdog0_reset_in |->
    ##[1:4] digital_reset_pin_oe_out) else $error("watchdog request did not reach reset pin");
  a_primary_first: assert property ($rose(secondary_reset_n_out) |->
    primary_reset_n_out) else $error("secondary left reset before primary");
  a_sec_held_por: assert property (!primary_reset_n_out |-> !secondary_reset_n_out)
    else $error("secondary out of reset while primary held");
  a_fault_restarts: assert property (boot_fault_out |=>
    !boot_fault_out && !app_running_out) else $error("fault not a single pulse ending the run");
  a_loader_done: assert property (app_running_out |-> !loader_active_out)
    else $error("loader still active while running");
  a_source_match: assert property (app_running_out |->
    boot_source_out == src_of(boot_mode_out))
    else $error("boot source does not match strap mode");
  a_mode_held: assert property (app_running_out && $past(app_running_out) |->
    $stable(boot_mode_out)) else $error("boot mode changed while running");
  a_wake_needed: assert property (secondary_idle_out &&
    !primary_to_secondary_wake_irq_in |=> $stable(secondary_entry_out) ||
    secondary_entry_out == 3'h0) else $error("woke without irq");
endmodule
bind dcbr_sequencer dcbr_checker dcbr_checker_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .watchdog0_reset_in(watchdog0_reset_in),
  .primary_to_secondary_wake_irq_in(primary_to_secondary_wake_irq_in),
  .digital_reset_pin_oe_out(digital_reset_pin_oe_out),
  .analog_reset_pin_oe_out(analog_reset_pin_oe_out), .gpio_tristate_out(gpio_tristate_out),
  .gpio_pullup_en_out(gpio_pullup_en_out), .primary_reset_n_out(primary_reset_n_out),
  .secondary_reset_n_out(secondary_reset_n_out), .boot_mode_out(boot_mode_out),
  .boot_source_out(boot_source_out), .loader_active_out(loader_active_out),
  .app_running_out(app_running_out),
  .boot_fault_out(boot_fault_out), .secondary_idle_out(secondary_idle_out),
  .secondary_entry_out(secondary_entry_out));

// ==== verification/dcbr_sequencer_tb.sv ====
// self-checking bench for the boot and reset sequencer
`timescale 1ns/100ps
module dcbr_sequencer_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] straps = 4'h7;
  logic [3:0] req = 4'h0;
  logic hold = 1'b0;
  logic flash_ok = 1'b1;
  logic rel = 1'b0;
  logic wake = 1'b0;
  logic stb = 1'b0;
  logic [31:0] cmd = 32'h00000000;
  logic loaded = 1'b1;
  wire dig_oe, ana_oe, dig_pin, ana_pin, tri_hz, pu_en, prim_n, sec_n, ana_n, run, fault, idle;
  wire dpo, apo, ld, sapp;
  wire [3:0] mode;
  wire [2:0] src, entry;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // short power-on count keeps each reboot brief
  dcbr_sequencer #(.POR_CYCLES(4)) dcbr_sequencer_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .strap_pins_in(straps), .core_irq_reset_in(req[0]), .watchdog0_reset_in(req[1]),
    .watchdog1_reset_in(req[2]), .nmi_watchdog_reset_in(req[3]), .digital_reset_pin_in(dig_pin),
    .analog_reset_pin_in(ana_pin), .image_loaded_in(loaded), .flash_valid_in(flash_ok),
    .secondary_core_reset_release_in(rel), .analog_interface_reset_release_in(rel),
    .primary_to_secondary_wake_irq_in(wake), .secondary_boot_command_value_in(cmd),
    .command_strobe_in(stb), .digital_reset_pin_out(dpo), .digital_reset_pin_oe_out(dig_oe),
    .analog_reset_pin_out(apo), .analog_reset_pin_oe_out(ana_oe), .gpio_tristate_out(tri_hz),
    .gpio_pullup_en_out(pu_en), .primary_reset_n_out(prim_n), .secondary_reset_n_out(sec_n),
    .analog_reset_n_out(ana_n), .boot_mode_out(mode), .boot_source_out(src),
    .loader_active_out(ld), .app_running_out(run), .boot_fault_out(fault),
    .secondary_idle_out(idle), .secondary_entry_out(entry), .secondary_app_out(sapp));
  dcbr_board dcbr_board_i (.dig_oe_in(dig_oe), .ana_oe_in(ana_oe), .hold_in(hold),
    .dig_pin_out(dig_pin), .ana_pin_out(ana_pin));
  // clock at 40 MHz
  always #12.5 clk_in = ~clk_in;
  // hang guard, well above the several hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // sample just after the edge so its updates have landed
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  task wait_done;
    for (int i = 0; i < 40 && run !== 1'b1 && fault !== 1'b1; i++) tick;
  endtask
  task boot(input logic [3:0] m, input logic ok);
    @(posedge clk_in);
    straps <= m;
    flash_ok <= ok;
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    tick;
    chk({dig_oe, ana_oe, tri_hz, sec_n, pu_en, dpo, apo}, 7'b1110000);
    wait_done;
  endtask
  // pulse the command strobe, optionally with the wake interrupt
  task send(input logic w, input logic [31:0] v);
    @(posedge clk_in);
    wake <= w;
    cmd <= v;
    stb <= 1'b1;
    @(posedge clk_in);
    stb <= 1'b0;
    wake <= 1'b0;
    repeat (3) tick;
  endtask
  // expected source per strap code; unlisted codes boot flash
  function automatic logic [2:0] exp_src(input logic [3:0] m);
    case (m)
      4'h0: return 3'h2;
      4'h1: return 3'h1;
      4'h2: return 3'h3;
      4'h3: return 3'h4;
      4'h4: return 3'h5;
      4'h9: return 3'h6;
      4'hA: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  initial begin
    repeat (20) @(posedge clk_in);
    for (int m = 0; m < 16; m++) begin
      boot(m[3:0], 1'b1);
      chk({run, src}, {1'b1, exp_src(m[3:0])});
      chk(mode, m[3:0]);
    end
    boot(4'h7, 1'b0);
    chk(fault, 1'b1);
    tick;
    wait_done;
    chk({fault, run}, 2'b10);
    // parallel loader waits for its image before the application runs
    @(posedge clk_in);
    loaded <= 1'b0;
    boot(4'h0, 1'b1);
    chk({ld, run}, 2'b10);
    @(posedge clk_in);
    loaded <= 1'b1;
    wait_done;
    chk({ld, run}, 2'b01);
    boot(4'hF, 1'b1);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      req <= 4'h1 << r;
      repeat (4) tick;
      chk({dig_oe, run}, 2'b10);
      @(posedge clk_in);
      req <= 4'h0;
      wait_done;
      chk(run, 1'b1);
    end
    @(posedge clk_in);
    hold <= 1'b1;
    repeat (8) tick;
    chk(run, 1'b0);
    @(posedge clk_in);
    hold <= 1'b0;
    wait_done;
    chk(run, 1'b1);
    for (int c = 1; c < 7; c++) begin
      boot(4'h7, 1'b1);
      chk({sec_n, ana_n}, 2'b00);
      @(posedge clk_in);
      rel <= 1'b1;
      @(posedge clk_in);
      rel <= 1'b0;
      for (int i = 0; i < 10 && idle !== 1'b1; i++) tick;
      chk({prim_n, sec_n, ana_n, idle}, 4'hF);
      send(1'b0, c);
      chk({sapp, entry}, 4'h0);
      send(1'b1, 32'h00000000);
      chk({sapp, entry}, 4'h0);
      send(1'b1, c);
      chk({sapp, entry}, {1'b1, c[2:0]});
    end
    send(1'b1, 32'h00000010);
    chk({sapp, entry}, 4'hF);
    tally_and_finish();
  end
endmodule
